// file: dv/his_irq_status_flags_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin numChecks++; if ((got) !== (ex)) begin failures++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end

module his_irq_status_flags_test;
    localparam int unsigned UNIT = 2;
    localparam int unsigned WT   = 5;

    logic        clk;
    logic        nrst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  pulse;
    logic [31:0] doneVec [3];
    logic        clksStable;
    logic        hostSuspended;
    logic        irq;
    logic        awake;
    int          failures;
    int          numChecks;
    int          seed;
    int          run;
    int          lastRun;
    int          k;
    logic [32:0] expQ [$];
    logic [32:0] note;

    his_irq_status_flags #(.NDESC(32), .UNIT_CYC(UNIT)) dut_u (
        .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .otgEvent(pulse[0]), .isoTdDone(pulse[1]), .bulkTdDone(pulse[2]), .pollTdDone(pulse[3]),
        .isoDoneVec(doneVec[0]), .bulkDoneVec(doneVec[1]), .pollDoneVec(doneVec[2]),
        .clksStable(clksStable), .hostSuspended(hostSuspended), .irq(irq), .awake(awake));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic give_verdict();
        $display("checks %0d failures %0d", numChecks, failures);
        if (failures == 0 && numChecks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // one apb transfer; the expected answer is queued for the monitor
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] ex,
                       input logic err);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        expQ.push_back({err, wr ? 32'h0 : ex});
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            failures++;
            give_verdict();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic err = 1'b0);
        apb(1'b1, a, d, 32'h0, err);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic err = 1'b0);
        apb(1'b0, a, 32'h0, ex, err);
    endtask

    // event i sets status bit 10-i; suspend level stays up until dropped
    task automatic fire(input int i);
        @(posedge clk);
        if (i < 4) pulse[i] <= 1'b1;
        else if (i == 4) clksStable <= 1'b1;
        else hostSuspended <= 1'b1;
        @(posedge clk);
        pulse      <= 4'h0;
        clksStable <= 1'b0;
    endtask

    task automatic setVec(input int l, input logic [31:0] v);
        @(posedge clk);
        doneVec[l] <= v;
        repeat (3) @(posedge clk);
    endtask

    // monitor: each answer is compared with the oldest queued note
    always @(posedge clk) begin
        if (nrst === 1'b1 && pready === 1'b1) begin
            if (expQ.size() == 0) begin
                `CHK("queue", 1'b1, 1'b0)
            end else begin
                note = expQ.pop_front();
                `CHK("prdata", note[31:0], prdata)
                `CHK("pslverr", note[32], pslverr)
            end
        end
        if (awake === 1'b1) run <= run + 1;
        else if (run > 0) begin
            lastRun <= run;
            run     <= 0;
        end
    end

    initial begin
        seed = 32'h2909;
        {nrst, psel, penable, pwrite, paddr, pwdata, pulse, clksStable, hostSuspended} = '0;
        doneVec = '{default: 32'h0};
        {failures, numChecks, run, lastRun} = '0;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        rd(his_pkg::STATUS_OFS, 32'h40);
        rd(his_pkg::ENABLE_OFS, 32'h0);
        rd(8'h00, 32'h0, 1'b1);
        wr(8'h04, $random(seed), 1'b1);
        wr(his_pkg::STATUS_OFS, 32'h40);
        rd(his_pkg::STATUS_OFS, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            fire(i);
            repeat (3) @(posedge clk);
            rd(his_pkg::STATUS_OFS, 32'h1 << (10 - i));
            wr(his_pkg::STATUS_OFS, ~(32'h1 << (10 - i)));
            rd(his_pkg::STATUS_OFS, 32'h1 << (10 - i));
            wr(his_pkg::STATUS_OFS, 32'h1 << (10 - i));
            rd(his_pkg::STATUS_OFS, 32'h0);
        end
        @(posedge clk);
        hostSuspended <= 1'b0;
        fire(0);
        wr(his_pkg::STATUS_OFS, ($random(seed) & 32'hfffff81f) | 32'hf800);
        rd(his_pkg::STATUS_OFS, 32'h400);
        wr(his_pkg::STATUS_OFS, 32'h400);
        $display("test flags done");
        for (int l = 0; l < 3; l++) begin
            wr(his_pkg::ISO_ALL_OFS + 8'(8 * l), 32'h3);
            setVec(l, 32'h1);
            rd(his_pkg::STATUS_OFS, 32'h0);
            setVec(l, 32'h3);
            rd(his_pkg::STATUS_OFS, 32'h1 << (9 - l));
            wr(his_pkg::STATUS_OFS, 32'h1 << (9 - l));
            setVec(l, 32'h0);
            wr(his_pkg::ISO_ALL_OFS + 8'(8 * l), 32'h0);
            k = $unsigned($random(seed)) % 32;
            wr(his_pkg::ISO_ANY_OFS + 8'(8 * l), 32'h1 << k);
            setVec(l, 32'h1 << k);
            rd(his_pkg::STATUS_OFS, 32'h1 << (9 - l));
            wr(his_pkg::STATUS_OFS, 32'h1 << (9 - l));
            wr(his_pkg::ISO_ANY_OFS + 8'(8 * l), 32'h0);
            setVec(l, 32'h0);
        end
        $display("test masks done");
        wr(his_pkg::CTRL_OFS, 32'h1);
        wr(his_pkg::ENABLE_OFS, 32'h400);
        rd(his_pkg::ENABLE_OFS, 32'h400);
        fire(1);
        repeat (3) @(posedge clk);
        `CHK("irq", 1'b0, irq)
        fire(0);
        repeat (3) @(posedge clk);
        `CHK("irq", 1'b1, irq)
        wr(his_pkg::CLEAR_OFS, 32'h400);
        repeat (3) @(posedge clk);
        `CHK("irq", 1'b0, irq)
        rd(his_pkg::STATUS_OFS, 32'h200);
        rd(his_pkg::CLEAR_OFS, 32'h0);
        wr(his_pkg::STATUS_OFS, 32'h200);
        wr(his_pkg::CTRL_OFS, 32'h0);
        fire(0);
        repeat (3) @(posedge clk);
        `CHK("irq", 1'b0, irq)
        rd(his_pkg::STATUS_OFS, 32'h400);
        wr(his_pkg::CTRL_OFS, 32'h1);
        repeat (3) @(posedge clk);
        `CHK("irq", 1'b1, irq)
        wr(his_pkg::STATUS_OFS, 32'h400);
        repeat (3) @(posedge clk);
        `CHK("irq", 1'b0, irq)
        $display("test irq done");
        wr(his_pkg::PWRDN_OFS, 32'(WT) << 16);
        fire(5);
        rd(his_pkg::STATUS_OFS, 32'h20);
        repeat (40) @(posedge clk);
        `CHK("wake", 32'(WT * UNIT), 32'(lastRun))
        @(posedge clk);
        hostSuspended <= 1'b0;
        wr(his_pkg::STATUS_OFS, 32'h20);
        repeat (4) @(posedge clk);
        $display("test wake done");
        give_verdict();
    end
endmodule

`undef CHK
`default_nettype wire

// file: src/his_irq_status_flags.sv
`timescale 1ns/1ps
`default_nettype none

module his_irq_status_flags #(
    parameter int unsigned NDESC    = 32,
    parameter int unsigned UNIT_CYC = his_pkg::WAKE_UNIT_CYC
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             nrst,
    // apb slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output var  logic [31:0]      prdata,
    output var  logic             pready,
    output var  logic             pslverr,
    // controller events
    input  wire logic             otgEvent,
    input  wire logic             isoTdDone,
    input  wire logic             bulkTdDone,
    input  wire logic             pollTdDone,
    input  wire logic [NDESC-1:0] isoDoneVec,
    input  wire logic [NDESC-1:0] bulkDoneVec,
    input  wire logic [NDESC-1:0] pollDoneVec,
    input  wire logic             clksStable,
    input  wire logic             hostSuspended,
    // outputs
    output var  logic             irq,
    output var  logic             awake
);

    typedef logic [NDESC-1:0] his_desc_t;

    // mask all/any combination for one descriptor list
    function automatic logic his_mask_hit(input his_desc_t done, input his_desc_t all, input his_desc_t any);
        his_mask_hit = ((all != '0) && ((done & all) == all)) || ((done & any) != '0);
    endfunction

    his_desc_t   maskAll_r [his_pkg::LIST_N];
    his_desc_t   maskAny_r [his_pkg::LIST_N];
    his_desc_t   doneVec   [his_pkg::LIST_N];
    logic [2:0]  tdDone;
    logic [2:0]  hit;
    logic [2:0]  hit_r;
    logic [2:0]  listEv;

    logic [15:0] status_r;
    logic [15:0] status_nxt;
    logic [15:0] enable_r;
    logic [15:0] wakeTime_r;
    logic        gate_r;
    logic        clkStable_r;
    logic        suspended_r;

    logic        setup;
    logic        access;
    logic        wrEn;
    logic        mapped;
    logic [31:0] rdMux;
    logic [15:0] setVec;
    logic [15:0] clrVec;
    logic        clkEv;
    logic        suspEv;
    logic        wakeStart;
    logic        pending;

    // apb phases and address decode
    assign setup  = psel && !penable;
    assign access = psel && penable && pready;
    assign wrEn   = access && pwrite && !pslverr;

    assign mapped = (paddr == his_pkg::PWRDN_OFS)    || (paddr == his_pkg::STATUS_OFS)   ||
                    (paddr == his_pkg::ENABLE_OFS)   || (paddr == his_pkg::CLEAR_OFS)    ||
                    (paddr == his_pkg::CTRL_OFS)     || (paddr == his_pkg::ISO_ALL_OFS)  ||
                    (paddr == his_pkg::ISO_ANY_OFS)  || (paddr == his_pkg::BULK_ALL_OFS) ||
                    (paddr == his_pkg::BULK_ANY_OFS) || (paddr == his_pkg::POLL_ALL_OFS) ||
                    (paddr == his_pkg::POLL_ANY_OFS);

    // clear register is write-only and reads zero
    assign rdMux = (paddr == his_pkg::PWRDN_OFS)    ? {wakeTime_r, 16'h0000} :
                   (paddr == his_pkg::STATUS_OFS)   ? {16'h0000, status_r} :
                   (paddr == his_pkg::ENABLE_OFS)   ? {16'h0000, enable_r} :
                   (paddr == his_pkg::CTRL_OFS)     ? {31'h0, gate_r} :
                   (paddr == his_pkg::ISO_ALL_OFS)  ? 32'(maskAll_r[his_pkg::LIST_ISO]) :
                   (paddr == his_pkg::ISO_ANY_OFS)  ? 32'(maskAny_r[his_pkg::LIST_ISO]) :
                   (paddr == his_pkg::BULK_ALL_OFS) ? 32'(maskAll_r[his_pkg::LIST_BULK]) :
                   (paddr == his_pkg::BULK_ANY_OFS) ? 32'(maskAny_r[his_pkg::LIST_BULK]) :
                   (paddr == his_pkg::POLL_ALL_OFS) ? 32'(maskAll_r[his_pkg::LIST_POLL]) :
                   (paddr == his_pkg::POLL_ANY_OFS) ? 32'(maskAny_r[his_pkg::LIST_POLL]) :
                   32'h00000000;

    // zero-wait slave: answer in the first access cycle
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= setup;
            pslverr <= setup && !mapped;
            prdata  <= (setup && !pwrite) ? rdMux : 32'h00000000;
        end
    end

    // descriptor completion per list
    assign doneVec[his_pkg::LIST_ISO]  = isoDoneVec;
    assign doneVec[his_pkg::LIST_BULK] = bulkDoneVec;
    assign doneVec[his_pkg::LIST_POLL] = pollDoneVec;
    assign tdDone = {pollTdDone, bulkTdDone, isoTdDone};

    for (genvar i = 0; i < his_pkg::LIST_N; i++) begin : g_list
        assign hit[i] = his_mask_hit(doneVec[i], maskAll_r[i], maskAny_r[i]);
        // single completion counts when the list has no masks; else a fresh mask match
        assign listEv[i] = (tdDone[i] && maskAll_r[i] == '0 && maskAny_r[i] == '0) || (hit[i] && !hit_r[i]);
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            hit_r       <= 3'h0;
            clkStable_r <= 1'b0;
            suspended_r <= 1'b0;
        end else begin
            hit_r       <= hit;
            clkStable_r <= clksStable;
            suspended_r <= hostSuspended;
        end
    end

    assign clkEv  = clksStable && !clkStable_r;
    assign suspEv = hostSuspended && !suspended_r;

    // event sources, independent of the gate
    assign setVec = {5'h00,
                     otgEvent,
                     listEv[his_pkg::LIST_ISO],
                     listEv[his_pkg::LIST_BULK],
                     listEv[his_pkg::LIST_POLL],
                     clkEv,
                     suspEv,
                     5'h00};

    assign clrVec = (wrEn && (paddr == his_pkg::STATUS_OFS || paddr == his_pkg::CLEAR_OFS)) ?
                    (pwdata[15:0] & his_pkg::STATUS_IMPL) : 16'h0000;

    // set wins over a clear in the same cycle
    assign status_nxt = ((status_r & ~clrVec) | setVec) & his_pkg::STATUS_IMPL;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            status_r <= his_pkg::STATUS_RST;
        end else begin
            status_r <= status_nxt;
        end
    end

    // software-written registers
    always_ff @(posedge clk) begin
        if (!nrst) begin
            enable_r   <= his_pkg::ENABLE_RST;
            wakeTime_r <= his_pkg::WAKE_RST;
            gate_r     <= his_pkg::GATE_RST;
        end else if (wrEn) begin
            if (paddr == his_pkg::ENABLE_OFS) begin
                enable_r <= pwdata[15:0] & his_pkg::STATUS_IMPL;
            end
            if (paddr == his_pkg::PWRDN_OFS) begin
                wakeTime_r <= pwdata[his_pkg::WAKE_MSB:his_pkg::WAKE_LSB];
            end
            if (paddr == his_pkg::CTRL_OFS) begin
                gate_r <= pwdata[his_pkg::GATE_BIT];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            for (int i = 0; i < his_pkg::LIST_N; i++) begin
                maskAll_r[i] <= '0;
                maskAny_r[i] <= '0;
            end
        end else if (wrEn) begin
            case (paddr)
                his_pkg::ISO_ALL_OFS:  maskAll_r[his_pkg::LIST_ISO]  <= pwdata[NDESC-1:0];
                his_pkg::ISO_ANY_OFS:  maskAny_r[his_pkg::LIST_ISO]  <= pwdata[NDESC-1:0];
                his_pkg::BULK_ALL_OFS: maskAll_r[his_pkg::LIST_BULK] <= pwdata[NDESC-1:0];
                his_pkg::BULK_ANY_OFS: maskAny_r[his_pkg::LIST_BULK] <= pwdata[NDESC-1:0];
                his_pkg::POLL_ALL_OFS: maskAll_r[his_pkg::LIST_POLL] <= pwdata[NDESC-1:0];
                his_pkg::POLL_ANY_OFS: maskAny_r[his_pkg::LIST_POLL] <= pwdata[NDESC-1:0];
                default: ;
            endcase
        end
    end

    // interrupt line: enabled pending flag behind the global gate
    assign pending = gate_r && ((status_r & enable_r) != 16'h0000);

    always_ff @(posedge clk) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= pending;
        end
    end

    // any access while the suspend flag is up and hostSuspended is still high wakes the device if the wake time is nonzero
    assign wakeStart = setup && status_r[his_pkg::SUSP_BIT] && hostSuspended;

    his_wake_timer #(
        .UNIT_CYC (UNIT_CYC)
    ) u_wake (
        .clk      (clk),
        .nrst     (nrst),
        .start    (wakeStart),
        .duration (wakeTime_r),
        .awake    (awake)
    );

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence sClrOtg;
        wrEn && (paddr == his_pkg::STATUS_OFS || paddr == his_pkg::CLEAR_OFS) && pwdata[his_pkg::OTG_BIT];
    endsequence

    sequence sPend2;
        (gate_r && (status_r & enable_r) != 16'h0000) [*2];
    endsequence

    sequence sStatusRead;
        setup && !pwrite && paddr == his_pkg::STATUS_OFS ##1 pready;
    endsequence

    sequence sWakeReq;
        setup && status_r[his_pkg::SUSP_BIT] && hostSuspended && wakeTime_r != 16'h0000;
    endsequence

    chk_otg_flag_set: assert property (otgEvent |=> status_r[his_pkg::OTG_BIT])
        else $error("otg flag not set after event");

    chk_ungated_set: assert property (!gate_r && otgEvent |=> status_r[his_pkg::OTG_BIT] && !irq)
        else $error("flag not set while gate closed");

    chk_iso_flag_set: assert property (isoTdDone && maskAll_r[0] == '0 && maskAny_r[0] == '0
                                       |=> status_r[his_pkg::ISO_BIT])
        else $error("iso flag not set after completion");

    chk_bulk_match: assert property ($rose(hit[1]) |=> status_r[his_pkg::BULK_BIT])
        else $error("bulk flag not set on mask match");

    chk_poll_flag_set: assert property (pollTdDone && maskAll_r[2] == '0 && maskAny_r[2] == '0
                                        |=> status_r[his_pkg::POLL_BIT])
        else $error("poll flag not set after completion");

    chk_clk_stable: assert property ($rose(clksStable) |=> status_r[his_pkg::CLK_BIT])
        else $error("clocks stable flag not set");

    chk_susp_flag_set: assert property ($rose(hostSuspended) |=> status_r[his_pkg::SUSP_BIT])
        else $error("suspend flag not set");

    chk_irq_follows: assert property (sPend2 |-> irq)
        else $error("interrupt missing for enabled flag");

    chk_irq_silent: assert property ((enable_r == 16'h0000) [*2] |-> !irq)
        else $error("interrupt raised with nothing enabled");

    chk_w1c_clear: assert property (sClrOtg ##0 !otgEvent |=> !status_r[his_pkg::OTG_BIT])
        else $error("write one did not clear flag");

    // only a one written to the status or clear word may drop the flag
    chk_flag_sticky: assert property (status_r[his_pkg::OTG_BIT] &&
                                      !(wrEn && (paddr == his_pkg::STATUS_OFS || paddr == his_pkg::CLEAR_OFS) &&
                                        pwdata[his_pkg::OTG_BIT])
                                      |=> status_r[his_pkg::OTG_BIT])
        else $error("flag dropped without clear");

    chk_resv_zero: assert property (sStatusRead |-> prdata[15:11] == 5'h00)
        else $error("reserved status bits read nonzero");

    chk_wake_start: assert property (sWakeReq |-> ##[1:2] awake)
        else $error("access during suspend did not wake");

endmodule

`default_nettype wire

// file: src/his_pkg.sv
package his_pkg;

    // register byte offsets
    localparam logic [7:0] PWRDN_OFS    = 8'hd0;
    localparam logic [7:0] STATUS_OFS   = 8'hd4;
    localparam logic [7:0] ENABLE_OFS   = 8'hd8;
    localparam logic [7:0] CLEAR_OFS    = 8'hdc;
    localparam logic [7:0] CTRL_OFS     = 8'he0;
    localparam logic [7:0] ISO_ALL_OFS  = 8'he4;
    localparam logic [7:0] ISO_ANY_OFS  = 8'he8;
    localparam logic [7:0] BULK_ALL_OFS = 8'hec;
    localparam logic [7:0] BULK_ANY_OFS = 8'hf0;
    localparam logic [7:0] POLL_ALL_OFS = 8'hf4;
    localparam logic [7:0] POLL_ANY_OFS = 8'hf8;

    // status and enable field positions
    localparam int unsigned OTG_BIT  = 10;
    localparam int unsigned ISO_BIT  = 9;
    localparam int unsigned BULK_BIT = 8;
    localparam int unsigned POLL_BIT = 7;
    localparam int unsigned CLK_BIT  = 6;
    localparam int unsigned SUSP_BIT = 5;

    // power-down register wake field and control gate position
    localparam int unsigned WAKE_LSB = 16;
    localparam int unsigned WAKE_MSB = 31;
    localparam int unsigned GATE_BIT = 0;

    // descriptor list indices
    localparam int unsigned LIST_ISO  = 0;
    localparam int unsigned LIST_BULK = 1;
    localparam int unsigned LIST_POLL = 2;
    localparam int unsigned LIST_N    = 3;

    // reset values and implemented-bit mask
    localparam logic [15:0] STATUS_IMPL = 16'h07e0;
    localparam logic [15:0] STATUS_RST  = 16'h0040;
    localparam logic [15:0] ENABLE_RST  = 16'h0000;
    localparam logic [15:0] WAKE_RST    = 16'h0000;
    localparam logic        GATE_RST    = 1'b0;

    // wake duration unit
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned WAKE_UNIT_NS  = 1000;
    localparam int unsigned WAKE_UNIT_CYC = (WAKE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// file: src/his_wake_timer.sv
`timescale 1ns/1ps
`default_nettype none

module his_wake_timer #(
    parameter int unsigned UNIT_CYC = his_pkg::WAKE_UNIT_CYC
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // control
    input  wire logic        start,
    input  wire logic [15:0] duration,
    // status
    output var  logic        awake
);

    localparam int unsigned DIV_W = (UNIT_CYC > 1) ? $clog2(UNIT_CYC) : 1;

    logic [DIV_W-1:0] div_r;
    logic [15:0]      remain_r;
    logic             tick;

    // one-cycle enable per wake unit
    assign tick = (div_r == DIV_W'(UNIT_CYC - 1));

    always_ff @(posedge clk) begin
        if (!nrst || start || tick) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            remain_r <= '0;
        end else if (start) begin
            remain_r <= duration;
        end else if (tick && remain_r != 16'h0000) begin
            remain_r <= remain_r - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            awake <= 1'b0;
        end else begin
            awake <= start ? (duration != 16'h0000) : (remain_r > 16'h0001 || (remain_r == 16'h0001 && !tick));
        end
    end

endmodule

`default_nettype wire
